// File: rtl/wsm_pkg.sv
// Package for the wake supervisor mask block: register map, field layout, timing.
// Assumes a 250 MHz pclk and an APB register slave.
package wsm_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned LONG_HOLD_US     = 150;
  localparam int unsigned SHORT_HOLD_US    = 2;
  localparam int unsigned OVERSHOOT_US     = 6;
  localparam int unsigned LONG_HOLD_CYC    = LONG_HOLD_US * CLK_MHZ;
  localparam int unsigned SHORT_HOLD_CYC   = SHORT_HOLD_US * CLK_MHZ;
  localparam int unsigned OVERSHOOT_CYC    = OVERSHOOT_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 16;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_SUPV_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_CLK_DIV    = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h14;
  localparam logic [7:0] ADDR_SLEEP      = 8'h18;

  // ----------------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------------
  localparam int unsigned SUPV_EN_BIT    = 0;
  localparam int unsigned MON_EN_BIT     = 1;
  localparam int unsigned SUPV_FAST_BIT  = 2;
  localparam int unsigned MON_FAST_BIT   = 3;
  localparam logic [3:0]  SUPV_CTRL_RST  = 4'h3;
  localparam logic [2:0]  DIV_RST        = 3'h0;
  localparam logic [2:0]  DIV_BY_TWO     = 3'h1;
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned EV_SUPV        = 0;
  localparam int unsigned EV_MON         = 1;
  localparam int unsigned EV_WAKE_DONE   = 2;
  localparam int unsigned EV_OVERSHOOT   = 3;

  typedef struct packed {
    logic       mon_fast;
    logic       supv_fast;
    logic       mon_en;
    logic       supv_en;
  } wsm_supv_t;

  typedef struct packed {
    logic       supv_trip;
    logic       mon_trip;
  } wsm_cmp_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_HOLD  = 3'b100
  } wsm_state_t;

endpackage

// File: rtl/wsm_hold_timer.sv
// Hold-off down counter for the wake supervisor mask block.
// Assumes load and the chosen duration come from the main file, same clock.
`timescale 1ns/1ps
`default_nettype none
module wsm_hold_timer
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Control
  input  wire logic                   load,
  input  wire logic                   use_long,
  // Status
  output logic                        busy,
  output logic                        over_win
);
  import wsm_pkg::*;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] age;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (load)
      count <= use_long ? CNT_W'(LONG_HOLD_CYC) : CNT_W'(SHORT_HOLD_CYC);
    else if (count != '0)
      count <= count - 1'b1;
  end

  // Age since wake, bounds the oscillator overshoot window.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age <= CNT_W'(OVERSHOOT_CYC);
    else if (load)
      age <= '0;
    else if (age != CNT_W'(OVERSHOOT_CYC))
      age <= age + 1'b1;
  end

  assign busy     = (count != '0);
  assign over_win = (age != CNT_W'(OVERSHOOT_CYC));
endmodule
`default_nettype wire

// File: rtl/wsm_top.sv
// Wake supervisor mask: gates core execution after deep-sleep wake and
// governs supervisor/monitor flag operation after a power-up clear.
// Assumes an APB master on pclk and comparator inputs synchronous to pclk.
//
// Notes on behaviour
// - After power-up clear with supervisor previously disabled, flags stay inoperative.
// - A software write to supervisor control afterwards restores both flag functions.
// - Oscillator may overshoot up to 6 us after leaving deep sleep.
// - Normal-performance supervisor and monitor hold execution off 150 us on wake.
// - Both disabled or both fast shortens the hold-off to 2 us.
// - Short hold-off exposes main clock when oscillator exceeds per-level ceiling.
`timescale 1ns/1ps
`default_nettype none
module wsm_top
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Power-up clear, synchronous pulse
  input  wire logic                   power_up_clear,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Wake and comparators
  input  wire logic                   wake,
  input  wire wsm_pkg::wsm_cmp_t      cmp,
  // Core and clock system
  output logic                        core_hold,
  output logic [2:0]                  main_clock_divider,
  output logic                        clock_exposed,
  output logic                        irq
);
  import wsm_pkg::*;

  wsm_supv_t      supv;
  logic           flags_dead;
  logic [2:0]     div;
  wsm_state_t     state;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic           sleep_req;
  logic           hold_load;
  logic           use_long;
  logic           busy;
  logic           over_win;
  logic           busy_d;
  logic           over_d;
  logic           short_mode;
  logic           wr_acc;
  logic           rd_acc;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] next_irq_en;
  logic [31:0]    next_prdata;
  logic           addr_hit;
  logic           wr_supv;
  logic           wr_div;
  logic           wr_sleep;
  logic           wr_irq_en;
  logic           wr_irq_clr;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  assign addr_hit = (paddr == ADDR_SUPV_CTRL) || (paddr == ADDR_CLK_DIV) ||
                    (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_STAT) ||
                    (paddr == ADDR_IRQ_EN) || (paddr == ADDR_IRQ_CLR) ||
                    (paddr == ADDR_SLEEP);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (psel && !penable)
      pslverr <= !addr_hit;
    else
      pslverr <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Register write strobes
  // ----------------------------------------------------------------------
  // Every write is qualified by the access edge with pready high, so no
  // register can change in the setup cycle or twice within one transfer.
  assign wr_supv    = wr_acc && pready && (paddr == ADDR_SUPV_CTRL);
  assign wr_div     = wr_acc && pready && (paddr == ADDR_CLK_DIV);
  assign wr_sleep   = wr_acc && pready && (paddr == ADDR_SLEEP);
  assign wr_irq_en  = wr_acc && pready && (paddr == ADDR_IRQ_EN);
  assign wr_irq_clr = wr_acc && pready && (paddr == ADDR_IRQ_CLR);

  // ----------------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (paddr)
      ADDR_SUPV_CTRL: next_prdata = {28'h0, supv};
      ADDR_CLK_DIV:   next_prdata = {29'h0, div};
      ADDR_STATUS:    next_prdata = {27'h0, short_mode, flags_dead, over_win,
                                     busy, state == ST_SLEEP};
      ADDR_IRQ_STAT:  next_prdata = {28'h0, irq_stat};
      ADDR_IRQ_EN:    next_prdata = {28'h0, irq_en};
      default:        next_prdata = 32'h0;
    endcase
  end

  // Read data is launched at the setup edge, so it stands through the access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (rd_acc)
      prdata <= next_prdata;
    else
      prdata <= '0;
  end

  // ----------------------------------------------------------------------
  // Supervisor control and power-up clear
  // ----------------------------------------------------------------------
  // Power-up clear re-enables both comparators but, mirroring the silicon,
  // leaves the flag path dead if the supervisor was off beforehand.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      supv <= SUPV_CTRL_RST;
    else if (power_up_clear)
      supv <= SUPV_CTRL_RST;
    else if (wr_supv)
      supv <= pwdata[3:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_dead <= 1'b0;
    else if (power_up_clear)
      flags_dead <= !supv.supv_en;
    else if (wr_supv)
      flags_dead <= 1'b0;
  end

  // Divider is software owned and cleared by power-up clear; the block forwards it to clock generation and gates clock_exposed on it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div <= DIV_RST;
    else if (power_up_clear)
      div <= DIV_RST;
    else if (wr_div)
      div <= pwdata[2:0];
  end

  assign sleep_req = wr_sleep && pwdata[0];

  // ----------------------------------------------------------------------
  // Sleep and wake sequencing
  // ----------------------------------------------------------------------
  assign short_mode = (!supv.supv_en && !supv.mon_en) ||
                      (supv.supv_fast && supv.mon_fast);
  assign use_long   = !short_mode;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_RUN;
    else if (power_up_clear)
      state <= ST_RUN;
    else
      case (state)
        ST_RUN:   if (sleep_req) state <= ST_SLEEP;
        ST_SLEEP: if (wake) state <= ST_HOLD;
        ST_HOLD:  if (!busy && !hold_load) state <= ST_RUN;
        default:  state <= ST_RUN;
      endcase
  end

  assign hold_load = (state == ST_SLEEP) && wake;

  wsm_hold_timer u_timer
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (hold_load),
    .use_long (use_long),
    .busy     (busy),
    .over_win (over_win)
  );

  // ----------------------------------------------------------------------
  // Core and clock outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_hold <= 1'b0;
    else
      core_hold <= (state == ST_SLEEP) || hold_load || busy;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      main_clock_divider <= DIV_RST;
    else
      main_clock_divider <= div;
  end

  // Only an undivided clock can outrun its ceiling while the core runs.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_exposed <= 1'b0;
    else
      clock_exposed <= over_win && !busy && !hold_load && (state != ST_SLEEP) &&
                       (div == DIV_RST);
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_d <= 1'b0;
      over_d <= 1'b0;
    end
    else
    begin
      busy_d <= busy;
      over_d <= over_win;
    end
  end

  assign ev[EV_SUPV]      = cmp.supv_trip && supv.supv_en && !flags_dead;
  assign ev[EV_MON]       = cmp.mon_trip && supv.mon_en && !flags_dead;
  assign ev[EV_WAKE_DONE] = busy_d && !busy;
  assign ev[EV_OVERSHOOT] = over_d && !over_win && short_mode;
  assign clr           = wr_irq_clr ? pwdata[IRQ_W-1:0] : '0;
  assign next_irq_stat = (irq_stat & ~clr) | ev;
  assign next_irq_en   = wr_irq_en ? pwdata[IRQ_W-1:0] : irq_en;

  // Set wins over a clear in the same cycle, so a trip that coincides with a
  // clear of the same bit is never lost.
  generate
    for (genvar gi = 0; gi < IRQ_W; gi = gi + 1)
    begin : g_irq
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          irq_stat[gi] <= 1'b0;
        else
          irq_stat[gi] <= next_irq_stat[gi];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          irq_en[gi] <= 1'b0;
        else
          irq_en[gi] <= next_irq_en[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------------
  // The level follows an enable written in the same cycle, so a masked bit
  // never leaves the line high for one stray cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(next_irq_stat & next_irq_en);
  end
endmodule
`default_nettype wire

// File: verif/wsm_core_model.sv
// Partner model: the core and clock system behind the hold gate.
// Assumes the block's hold and clock outputs on the same pclk.
`timescale 1ns/1ps
`default_nettype none
module wsm_core_model
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // From the block
  input  wire logic        core_hold,
  input  wire logic [2:0]  main_clock_divider,
  input  wire logic        clock_exposed,
  // Seen by the bench
  output logic [31:0]      fast_cycles
);
  // A core that runs undivided in the window executes on the fast clock.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      fast_cycles <= '0;
    else if (clock_exposed && !core_hold && main_clock_divider == 3'h0)
      fast_cycles <= fast_cycles + 32'h1;
endmodule
`default_nettype wire

// File: verif/wsm_checker_assertions.sv
// Port checker for wsm_top: hold-off, exposure and bus timing.
// Assumes it is bound into wsm_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module wsm_checker
  import wsm_pkg::*;
(
  // Watched ports
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        power_up_clear,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        wake,
  input  wire logic        core_hold,
  input  wire logic [2:0]  main_clock_divider,
  input  wire logic        clock_exposed
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Long spans are counted here, as repetitions that long would stall tools.
  logic [16:0] wcnt;
  logic [16:0] ecnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wcnt <= '0;
    else if (!core_hold || power_up_clear)
      wcnt <= '0;
    else if (wake || wcnt != 0)
      wcnt <= wcnt + 17'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ecnt <= '0;
    else
      ecnt <= clock_exposed ? ecnt + 17'h1 : 17'h0;
  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_in_access: assert property (pslverr |-> pready)
    else $error("error outside access");
  a_hold_min: assert property (wcnt != 0 && wcnt < SHORT_HOLD_CYC |-> core_hold)
    else $error("hold released early");
  a_hold_max: assert property (wcnt <= LONG_HOLD_CYC + 3)
    else $error("hold too long");
  a_sleep_holds: assert property (psel && penable && pready && pwrite && paddr == ADDR_SLEEP
    && pwdata[0] && !power_up_clear |-> ##[1:2] core_hold)
    else $error("sleep did not hold core");
  a_expose_div: assert property (clock_exposed |-> main_clock_divider == DIV_RST && !core_hold)
    else $error("exposed with divider or hold");
  a_expose_span: assert property (ecnt <= OVERSHOOT_CYC)
    else $error("exposure window too long");
  a_puc_div: assert property (power_up_clear |-> ##2 main_clock_divider == DIV_RST)
    else $error("divider kept over clear");
  a_div_cause: assert property ($changed(main_clock_divider) |->
    $past(psel && pwrite && paddr == ADDR_CLK_DIV, 2) || $past(power_up_clear, 2))
    else $error("divider changed unasked");
  c_long_hold: cover property (wcnt == LONG_HOLD_CYC);
  c_exposed: cover property ($rose(clock_exposed));
  c_slverr: cover property (pslverr);
endmodule
bind wsm_top wsm_checker i_wsm_checker (.pclk, .presetn, .power_up_clear, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .wake, .core_hold, .main_clock_divider,
  .clock_exposed);
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for wsm_top with a register model and core model.
// Assumes the package, design and core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wsm_pkg::*;
  logic        pclk, presetn, power_up_clear, psel, penable, pwrite, wake;
  logic        pready, pslverr, core_hold, clock_exposed, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, fast_cycles;
  logic [2:0]  main_clock_divider;
  wsm_cmp_t    cmp;
  int          err_total, check_count, m_ctrl, m_div, n, fbase;

  wsm_top i_wsm_top (.pclk, .presetn, .power_up_clear, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .wake, .cmp, .core_hold, .main_clock_divider,
    .clock_exposed, .irq);
  wsm_core_model i_wsm_core_model (.pclk, .presetn, .core_hold, .main_clock_divider,
    .clock_exposed, .fast_cycles);

  initial
  begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  // --------------------------------------------
  // Tasks
  // --------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One transfer, then an idle edge; the model follows writes.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (w && a == ADDR_SUPV_CTRL)
      m_ctrl = d[3:0];
    if (w && a == ADDR_CLK_DIV)
      m_div = d[2:0];
  endtask

  task automatic trip(input logic [31:0] exp_irq);
    cmp <= 2'b11;
    @(posedge pclk);
    cmp <= 2'b00;
    repeat (3) @(posedge pclk);
    chk(irq, exp_irq);
  endtask

  task automatic hold(input int expc);
    apb(1'b1, ADDR_SLEEP, 32'h1);
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    n = 0;
    while (core_hold !== 1'b0)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n >= expc - 1 && n <= expc + 3, 1);
  endtask

  // --------------------------------------------
  // Sequence
  // --------------------------------------------
  initial
  begin
    {presetn, power_up_clear, psel, penable, pwrite, wake} = '0;
    paddr = '0;
    pwdata = '0;
    cmp = '0;
    {err_total, check_count, m_ctrl, m_div} = {32'd0, 32'd0, 32'd3, 32'd0};
    void'($urandom(14));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_SUPV_CTRL, 0);
    chk(rd, m_ctrl);
    apb(1'b0, 8'h1c, 0);
    chk(err, 1);
    repeat (4)
    begin
      apb(1'b1, ADDR_CLK_DIV, $urandom % 8);
      @(posedge pclk);
      chk(main_clock_divider, m_div);
    end
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    apb(1'b1, ADDR_SUPV_CTRL, 32'h0);
    power_up_clear <= 1'b1;
    @(posedge pclk);
    power_up_clear <= 1'b0;
    m_ctrl = 3;
    m_div = 0;
    repeat (2) @(posedge pclk);
    chk(main_clock_divider, m_div);
    apb(1'b0, ADDR_STATUS, 0);
    chk(rd[3], 1);
    trip(0);
    apb(1'b1, ADDR_SUPV_CTRL, 32'h3);
    trip(1);
    apb(1'b1, ADDR_IRQ_EN, 32'h4);
    chk(irq, 0);
    apb(1'b1, ADDR_IRQ_CLR, 32'hf);
    hold(LONG_HOLD_CYC);
    apb(1'b0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h4);
    chk(irq, 1);
    apb(1'b1, ADDR_IRQ_CLR, 32'hf);
    chk(irq, 0);
    apb(1'b1, ADDR_SUPV_CTRL, 32'h0);
    apb(1'b1, ADDR_CLK_DIV, 32'h0);
    hold(SHORT_HOLD_CYC);
    repeat (OVERSHOOT_CYC) @(posedge pclk);
    chk(fast_cycles != 0, 1);
    fbase = fast_cycles;
    apb(1'b1, ADDR_SUPV_CTRL, 32'hf);
    apb(1'b1, ADDR_CLK_DIV, DIV_BY_TWO);
    hold(SHORT_HOLD_CYC);
    repeat (100) @(posedge pclk);
    chk(fast_cycles, fbase);
    apb(1'b1, ADDR_CLK_DIV, 32'h0);
    close_out();
  end

  // The planned run is near 40200 cycles; this cuts a hang short.
  initial
  begin
    #240000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
